// File: bench/bmda_asserts.sv
`timescale 1ns/100ps
// ======
// port relations of the matrix
module bmda_asserts (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  // control
  input wire logic [1:0]           remap_control_bit,
  // masters
  input wire logic [4:0]           m_req,
  input wire logic [4:0][31:0]     m_addr,
  input wire logic [4:0]           m_done,
  input wire logic [4:0]           m_err,
  // slaves
  input wire logic [4:0]           s_sel,
  input wire logic [4:0][31:0]     s_addr,
  input wire logic [4:0][2:0]      s_master,
  input wire logic [4:0]           s_ready,
  input wire logic [7:0]           external_chip_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  for (genvar m = 0; m < 5; m++) begin : g_m
    abort_resp_a:
      assert property (m_req[m] && !m_done[m] && m_addr[m][31:28] inside {[4'h9:4'he]}
        |=> m_done[m] && m_err[m]) else $error("abort not answered next cycle");
    err_done_a:
      assert property (m_err[m] |-> m_done[m]) else $error("error without done");
    req_served_a:
      assert property (m_req[m] && !m_done[m] |-> ##[1:60] m_done[m])
      else $error("request starved");
  end
  for (genvar s = 0; s < 5; s++) begin : g_s
    sel_hold_a:
      assert property (s_sel[s] && !s_ready[s] |=> s_sel[s] && $stable(s_addr[s]))
      else $error("slave request dropped early");
    done_owner_a:
      assert property (s_sel[s] && s_ready[s] |=> !s_sel[s] && m_done[$past(s_master[s])])
      else $error("completion not returned to owner");
  end
  ext_cs_a:
    assert property (s_sel[3] && s_addr[3][31:28] != 4'h0
      |-> external_chip_select == 8'h01 << (s_addr[3][31:28] - 4'h1)) else $error("bad chip select");
  boot_cs_a:
    assert property (s_sel[3] && s_addr[3][31:28] == 4'h0 |-> external_chip_select == 8'h01)
    else $error("boot not on chip select zero");
  cs_idle_a:
    assert property (!s_sel[3] |-> external_chip_select == 8'h00) else $error("stray chip select");
  peri_route_a:
    assert property (s_sel[4] |-> s_addr[4][31:28] == 4'hf) else $error("bad peripheral route");
  sram_route_a:
    assert property (s_sel[0] |-> s_addr[0][31:20] == 12'h003 || (s_addr[0][31:20] == 12'h000
      && s_master[0] < 3'h2 && remap_control_bit[s_master[0][0]])) else $error("bad sram route");
  rom_route_a:
    assert property (s_sel[1] |-> s_addr[1][31:20] inside {12'h000, 12'h004})
    else $error("bad rom route");
endmodule : bmda_asserts

// File: bench/bmda_slave_model.sv
`timescale 1ns/100ps
// ======
// five slaves, each answering after a set number of wait cycles
module bmda_slave_model (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // matrix side
  input  wire logic [4:0]          s_sel,
  input  wire logic [4:0][31:0]    s_addr,
  output logic      [4:0]          s_ready,
  output logic      [4:0][31:0]    s_rdata,
  // bench control
  input  wire logic [4:0][3:0]     wait_cyc
);
  logic [4:0][3:0] cnt_q;
  logic [31:0]     noise_q;
  // data lines change every cycle when idle so a stale word is never mistaken for an answer
  always_ff @(posedge sys_clk) begin
    noise_q <= sys_rst ? 32'h0 : noise_q + 32'h9e37_79b9;
    for (int s = 0; s < 5; s++) begin
      cnt_q[s] <= (s_sel[s] && !s_ready[s]) ? cnt_q[s] + 4'h1 : 4'h0;
    end
  end
  for (genvar s = 0; s < 5; s++) begin : g_s
    assign s_ready[s] = s_sel[s] && cnt_q[s] == wait_cyc[s];
    assign s_rdata[s] = s_ready[s] ? ~s_addr[s] : noise_q;
  end
endmodule : bmda_slave_model

// File: bench/test_bus_matrix_decode_arbiter.sv
`timescale 1ns/100ps
bind bmda_matrix bmda_asserts bmda_asserts_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .remap_control_bit(remap_control_bit),
  .m_req(m_req), .m_addr(m_addr), .m_done(m_done), .m_err(m_err), .s_sel(s_sel),
  .s_addr(s_addr), .s_master(s_master), .s_ready(s_ready),
  .external_chip_select(external_chip_select)
);
// ======
// bench top
module test_bus_matrix_decode_arbiter;
  logic                  sys_clk, sys_rst, boot_select_pin;
  logic [1:0]            remap_control_bit;
  logic [4:0][1:0]       arb_policy;
  logic [4:0][2:0]       arb_fixed_master, s_master;
  logic [4:0][7:0]       arb_slot_limit;
  logic [4:0]            m_req, m_write, m_done, m_err, s_sel, s_write, s_ready;
  logic [4:0][31:0]      m_addr, m_wdata, m_rdata, s_addr, s_wdata, s_rdata;
  logic [7:0]            external_chip_select;
  logic [4:0][3:0]       wait_cyc;
  int                    n_fail = 0, n_tests = 0, cycles = 0;
  int                    order[$];

  bmda_matrix #(.SLOT_W(8)) bmda_matrix_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .boot_select_pin(boot_select_pin),
    .remap_control_bit(remap_control_bit), .arb_policy(arb_policy),
    .arb_fixed_master(arb_fixed_master), .arb_slot_limit(arb_slot_limit),
    .m_req(m_req), .m_addr(m_addr), .m_write(m_write), .m_wdata(m_wdata),
    .m_done(m_done), .m_err(m_err), .m_rdata(m_rdata), .s_sel(s_sel), .s_addr(s_addr),
    .s_write(s_write), .s_wdata(s_wdata), .s_master(s_master), .s_ready(s_ready),
    .s_rdata(s_rdata), .external_chip_select(external_chip_select)
  );
  bmda_slave_model bmda_slave_model_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_sel(s_sel), .s_addr(s_addr),
    .s_ready(s_ready), .s_rdata(s_rdata), .wait_cyc(wait_cyc)
  );

  // ======
  // helpers
  task complete_run();
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset(logic pin);
    sys_rst = 1'b1;
    boot_select_pin = pin;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask : do_reset

  // request stays up on return so a caller may chain the next word; slave 7 means none
  task automatic xfer(int m, logic [31:0] a, logic w, output logic [2:0] sl,
                      output logic [7:0] cs, output logic er, output int lat);
    lat = 0;
    sl = 3'h7;
    cs = 8'h00;
    m_addr[m] = a;
    m_write[m] = w;
    m_wdata[m] = ~a;
    m_req[m] = 1'b1;
    do begin
      @(negedge sys_clk);
      lat++;
      for (int s = 0; s < 5; s++) begin
        if (s_sel[s] && s_master[s] == m) begin
          sl = 3'(s);
          check("slave address", s_addr[s], a);
          check("slave write", s_write[s], w);
          check("slave write data", s_wdata[s], ~a);
          if (s == 3) cs = external_chip_select;
        end
      end
    end while (m_done[m] !== 1'b1 && lat < 60);
    er = m_err[m];
    order.push_back(m);
    check("done", m_done[m], 1'b1);
    if (!w) check("read data", m_rdata[m], er ? 32'h0 : ~a);
  endtask : xfer

  task automatic go(int m, logic [31:0] a, logic [2:0] esl, logic [7:0] ecs);
    logic [2:0] sl;
    logic [7:0] cs;
    logic       er;
    int         lat;
    xfer(m, a, 1'b0, sl, cs, er, lat);
    m_req[m] = 1'b0;
    check("slave", sl, esl);
    check("chip select", cs, ecs);
    check("abort", er, esl == 3'h7);
    @(negedge sys_clk);
  endtask : go

  task automatic two(int m);
    logic [2:0] sl;
    logic [7:0] cs;
    logic       er;
    int         lat;
    xfer(m, 32'h0030_0100, 1'b0, sl, cs, er, lat);
    xfer(m, 32'h0030_0200, 1'b0, sl, cs, er, lat);
    m_req[m] = 1'b0;
  endtask : two

  // ======
  // scenarios
  task automatic t_map();
    go(2, 32'h0030_0010, 3'h0, 8'h00);
    go(3, 32'h0040_0004, 3'h1, 8'h00);
    go(4, 32'h0050_0000, 3'h2, 8'h00);
    go(2, 32'h0060_0000, 3'h2, 8'h00);
    go(4, 32'h0070_0000, 3'h7, 8'h00);
    go(3, 32'hf000_0100, 3'h4, 8'h00);
    for (int r = 1; r <= 8; r++) go(r % 5, {r[3:0], 28'h123_4560}, 3'h3, 8'h01 << (r - 1));
    for (int r = 9; r <= 14; r++) go(r % 5, {r[3:0], 28'h0}, 3'h7, 8'h00);
  endtask : t_map

  task automatic t_boot();
    boot_select_pin = 1'b0;
    go(0, 32'h0000_0100, 3'h1, 8'h00);
    remap_control_bit = 2'b01;
    go(0, 32'h0000_0100, 3'h0, 8'h00);
    go(1, 32'h0000_0100, 3'h1, 8'h00);
    go(2, 32'h0000_0100, 3'h1, 8'h00);
    go(0, 32'h0040_0100, 3'h1, 8'h00);
    remap_control_bit = 2'b00;
    do_reset(1'b0);
    go(1, 32'h0000_0200, 3'h3, 8'h01);
    remap_control_bit = 2'b10;
    go(1, 32'h0000_0200, 3'h0, 8'h00);
    go(0, 32'h0000_0200, 3'h3, 8'h01);
    remap_control_bit = 2'b00;
  endtask : t_boot

  task automatic t_pol();
    logic [2:0] sl;
    logic [7:0] cs;
    logic       er;
    int         lat;
    arb_fixed_master[0] = 3'h2;
    for (int p = 0; p < 3; p++) begin
      arb_policy[0] = p[1:0];
      xfer(2, 32'h0030_0000, 1'b0, sl, cs, er, lat);
      m_req[2] = 1'b0;
      repeat (3) @(negedge sys_clk);
      xfer(2, 32'h0030_0040, 1'b1, sl, cs, er, lat);
      m_req[2] = 1'b0;
      check("latency", lat, p == 0 ? 3 : 2);
      @(negedge sys_clk);
    end
  endtask : t_pol

  // three masters take turns; then a lone master loses a cycle once its slot is spent
  task automatic t_rr();
    logic [2:0] sl;
    logic [7:0] cs;
    logic       er;
    int         lat;
    order = {};
    arb_slot_limit[0] = 8'h01;
    wait_cyc[0] = 4'h2;
    fork
      two(2);
      two(3);
      two(4);
    join
    check("turns", order[0] != order[1] && order[1] != order[2] && order[0] != order[2], 1'b1);
    @(negedge sys_clk);
    xfer(2, 32'h0030_0300, 1'b0, sl, cs, er, lat);
    xfer(2, 32'h0030_0304, 1'b0, sl, cs, er, lat);
    m_req[2] = 1'b0;
    check("burst break latency", lat, 6);
    arb_slot_limit[0] = 8'h00;
    wait_cyc[0] = 4'h0;
  endtask : t_rr

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    {remap_control_bit, m_req, m_write, arb_policy, arb_fixed_master} = '0;
    {m_addr, m_wdata, arb_slot_limit} = '0;
    wait_cyc = {4'h1, 4'h3, 4'h0, 4'h0, 4'h0};
    do_reset(1'b1);
    t_map();
    t_boot();
    t_pol();
    t_rr();
    complete_run();
  end
endmodule : test_bus_matrix_decode_arbiter

// File: pkg/bmda_arb_if.sv
`timescale 1ns/100ps
interface bmda_arb_if #(
  parameter int unsigned SLOT_W = bmda_pkg::SLOT_W_DEF
);
  logic [bmda_pkg::NUM_M-1:0]  req;
  logic                        busy;
  logic [1:0]                  policy;
  logic [bmda_pkg::MIDX_W-1:0] fixed;
  logic [SLOT_W-1:0]           limit;
  logic [bmda_pkg::MIDX_W-1:0] owner;
  logic                        go;

  modport arb (input req, busy, policy, fixed, limit, output owner, go);
  modport mtx (output req, busy, policy, fixed, limit, input owner, go);
endinterface : bmda_arb_if

// File: pkg/bmda_pkg.sv
package bmda_pkg;

  // ==========================================================
  // ports
  localparam int unsigned NUM_M   = 5;
  localparam int unsigned NUM_S   = 5;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned MIDX_W  = 3;
  localparam int unsigned SIDX_W  = 3;

  localparam logic [SIDX_W-1:0] S_SRAM = 3'h0;
  localparam logic [SIDX_W-1:0] S_ROM  = 3'h1;
  localparam logic [SIDX_W-1:0] S_HOST = 3'h2;
  localparam logic [SIDX_W-1:0] S_EXT  = 3'h3;
  localparam logic [SIDX_W-1:0] S_PERI = 3'h4;

  // ==========================================================
  // address map
  localparam int unsigned REG_HI = 31;
  localparam int unsigned REG_LO = 28;
  localparam int unsigned MB_HI  = 27;
  localparam int unsigned MB_LO  = 20;

  localparam logic [3:0] REG_INT      = 4'h0;
  localparam logic [3:0] REG_EXT_FIRST = 4'h1;
  localparam logic [3:0] REG_EXT_LAST = 4'h8;
  localparam logic [3:0] REG_PERI     = 4'hf;

  localparam logic [7:0] MB_BOOT = 8'h00;
  localparam logic [7:0] MB_SRAM = 8'h03;
  localparam logic [7:0] MB_ROM  = 8'h04;
  localparam logic [7:0] MB_USBH = 8'h05;
  localparam logic [7:0] MB_DISP = 8'h06;

  localparam logic [2:0] CS_BOOT = 3'h0;

  // ==========================================================
  // arbitration
  localparam logic [1:0] POL_NONE  = 2'h0;
  localparam logic [1:0] POL_LAST  = 2'h1;
  localparam logic [1:0] POL_FIXED = 2'h2;

  localparam int unsigned SLOT_W_DEF = 8;

  typedef enum logic [1:0] {
    BMDA_IDLE = 2'b01,
    BMDA_BUSY = 2'b10
  } bmda_port_e;

  typedef struct packed {
    logic              valid;
    logic [SIDX_W-1:0] slave;
    logic [2:0]        cs;
  } bmda_dec_s;

endpackage : bmda_pkg

// File: src/bmda_arbiter.sv
`timescale 1ns/100ps
module bmda_arbiter #(
  parameter int unsigned SLOT_W = bmda_pkg::SLOT_W_DEF
) (
  // clock and reset
  input wire logic    sys_clk,
  input wire logic    sys_rst,
  // matrix side
  bmda_arb_if.arb     a
);

  typedef struct packed {
    logic [bmda_pkg::MIDX_W-1:0] owner;
    logic                        vld;
    logic [SLOT_W-1:0]           count;
  } bmda_arb_s;

  bmda_arb_s q;
  bmda_arb_s d;
  logic      expired;
  logic      found;
  logic [bmda_pkg::MIDX_W-1:0] pick;

  // ==========================================================
  // round robin search, starting just after the current owner
  always_comb begin
    int unsigned start;
    int unsigned j;
    j     = 0;
    start = q.vld ? int'(q.owner) : bmda_pkg::NUM_M - 1;
    found = 1'b0;
    pick  = '0;
    for (int unsigned i = 1; i <= bmda_pkg::NUM_M; i++) begin
      j = (start + i) % bmda_pkg::NUM_M;
      if (!found && a.req[j]) begin
        found = 1'b1;
        pick  = bmda_pkg::MIDX_W'(j);
      end
    end
  end

  // a zero limit means bursts are never broken
  assign expired = (a.limit != '0) && (q.count >= a.limit);
  assign a.go    = q.vld && a.req[q.owner] && !a.busy && !expired;
  assign a.owner = q.owner;

  // ==========================================================
  // grant update, frozen while the slave is busy
  always_comb begin
    d = q;
    if (a.go) begin
      if (q.count != '1) begin
        d.count = q.count + 1'b1;
      end
    end else if (!a.busy) begin
      if (found) begin
        d.owner = pick;
        d.vld   = 1'b1;
        d.count = '0;
      end else begin
        unique case (a.policy)
          bmda_pkg::POL_NONE: begin
            d.vld = 1'b0;
          end
          bmda_pkg::POL_FIXED: begin
            if (!q.vld || q.owner != a.fixed) begin
              d.count = '0;
            end
            d.owner = a.fixed;
            d.vld   = 1'b1;
          end
          default: begin
            d.vld = q.vld;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : bmda_arbiter

// File: src/bmda_matrix.sv
`timescale 1ns/100ps
module bmda_matrix #(
  parameter int unsigned SLOT_W = bmda_pkg::SLOT_W_DEF
) (
  // clock and reset
  input  wire logic                                              sys_clk,
  input  wire logic                                              sys_rst,
  // boot and remap control
  input  wire logic                                              boot_select_pin,
  input  wire logic [1:0]                                        remap_control_bit,
  // arbitration setup, one set per slave
  input  wire logic [bmda_pkg::NUM_S-1:0][1:0]                   arb_policy,
  input  wire logic [bmda_pkg::NUM_S-1:0][bmda_pkg::MIDX_W-1:0]  arb_fixed_master,
  input  wire logic [bmda_pkg::NUM_S-1:0][SLOT_W-1:0]            arb_slot_limit,
  // master ports
  input  wire logic [bmda_pkg::NUM_M-1:0]                        m_req,
  input  wire logic [bmda_pkg::NUM_M-1:0][bmda_pkg::ADDR_W-1:0]  m_addr,
  input  wire logic [bmda_pkg::NUM_M-1:0]                        m_write,
  input  wire logic [bmda_pkg::NUM_M-1:0][bmda_pkg::DATA_W-1:0]  m_wdata,
  output logic      [bmda_pkg::NUM_M-1:0]                        m_done,
  output logic      [bmda_pkg::NUM_M-1:0]                        m_err,
  output logic      [bmda_pkg::NUM_M-1:0][bmda_pkg::DATA_W-1:0]  m_rdata,
  // slave ports
  output logic      [bmda_pkg::NUM_S-1:0]                        s_sel,
  output logic      [bmda_pkg::NUM_S-1:0][bmda_pkg::ADDR_W-1:0]  s_addr,
  output logic      [bmda_pkg::NUM_S-1:0]                        s_write,
  output logic      [bmda_pkg::NUM_S-1:0][bmda_pkg::DATA_W-1:0]  s_wdata,
  output logic      [bmda_pkg::NUM_S-1:0][bmda_pkg::MIDX_W-1:0]  s_master,
  input  wire logic [bmda_pkg::NUM_S-1:0]                        s_ready,
  input  wire logic [bmda_pkg::NUM_S-1:0][bmda_pkg::DATA_W-1:0]  s_rdata,
  // external bus chip selects, one hot
  output logic      [7:0]                                        external_chip_select
);

  localparam int unsigned NM = bmda_pkg::NUM_M;
  localparam int unsigned NS = bmda_pkg::NUM_S;

  typedef struct packed {
    logic [NM-1:0]                       done;
    logic [NM-1:0]                       err;
    logic [NM-1:0][bmda_pkg::DATA_W-1:0] rdata;
    bmda_pkg::bmda_port_e [NS-1:0]       st;
    logic [NS-1:0]                       sel;
    logic [NS-1:0][bmda_pkg::ADDR_W-1:0] addr;
    logic [NS-1:0]                       wr;
    logic [NS-1:0][bmda_pkg::DATA_W-1:0] wdata;
    logic [NS-1:0][bmda_pkg::MIDX_W-1:0] mst;
    logic [7:0]                          cs;
    logic                                boot;
  } bmda_mtx_s;

  bmda_mtx_s q;
  bmda_mtx_s d;

  // ==========================================================
  // address decode, private to each master
  function automatic bmda_pkg::bmda_dec_s bmda_decode(
    input logic [bmda_pkg::ADDR_W-1:0] addr,
    input logic                        cpu,
    input logic                        remap,
    input logic                        boot
  );
    bmda_pkg::bmda_dec_s r;
    logic [3:0] region;
    logic [7:0] mb;
    r      = '0;
    region = addr[bmda_pkg::REG_HI:bmda_pkg::REG_LO];
    mb     = addr[bmda_pkg::MB_HI:bmda_pkg::MB_LO];
    if (region == bmda_pkg::REG_INT) begin
      r.valid = 1'b1;
      // unmapped megabytes of region zero fall to the default and abort
      unique case (mb)
        bmda_pkg::MB_BOOT: begin
          if (cpu && remap) begin
            r.slave = bmda_pkg::S_SRAM;
          end else if (boot) begin
            r.slave = bmda_pkg::S_ROM;
          end else begin
            r.slave = bmda_pkg::S_EXT;
            r.cs    = bmda_pkg::CS_BOOT;
          end
        end
        bmda_pkg::MB_SRAM: r.slave = bmda_pkg::S_SRAM;
        bmda_pkg::MB_ROM:  r.slave = bmda_pkg::S_ROM;
        bmda_pkg::MB_USBH: r.slave = bmda_pkg::S_HOST;
        bmda_pkg::MB_DISP: r.slave = bmda_pkg::S_HOST;
        default:           r.valid = 1'b0;
      endcase
    end else if (region >= bmda_pkg::REG_EXT_FIRST && region <= bmda_pkg::REG_EXT_LAST) begin
      r.valid = 1'b1;
      r.slave = bmda_pkg::S_EXT;
      r.cs    = 3'(region - bmda_pkg::REG_EXT_FIRST);
    end else if (region == bmda_pkg::REG_PERI) begin
      r.valid = 1'b1;
      r.slave = bmda_pkg::S_PERI;
    end
    return r;
  endfunction : bmda_decode

  // only the two processor ports see the boot area move
  function automatic logic bmda_is_cpu(input int unsigned m);
    return m < 2;
  endfunction : bmda_is_cpu

  bmda_pkg::bmda_dec_s [NM-1:0] dec;
  logic [NS-1:0][NM-1:0]        want;
  logic [NM-1:0]                live;

  // a master is ignored in the cycle its answer shows, since it still holds
  // the old request then and would otherwise be served twice
  assign live = m_req & ~q.done;

  always_comb begin
    want = '0;
    for (int unsigned m = 0; m < NM; m++) begin
      dec[m] = bmda_decode(m_addr[m], bmda_is_cpu(m),
                           bmda_is_cpu(m) ? remap_control_bit[m[0]] : 1'b0,
                           q.boot);
      if (live[m] && dec[m].valid) begin
        want[dec[m].slave][m] = 1'b1;
      end
    end
  end

  // ==========================================================
  // one arbiter per slave
  bmda_arb_if #(.SLOT_W(SLOT_W)) arb_if [NS] ();

  logic [NS-1:0]                       go;
  logic [NS-1:0][bmda_pkg::MIDX_W-1:0] owner;

  for (genvar s = 0; s < NS; s++) begin : g_arb
    assign arb_if[s].req    = want[s];
    assign arb_if[s].busy   = (q.st[s] == bmda_pkg::BMDA_BUSY);
    assign arb_if[s].policy = arb_policy[s];
    assign arb_if[s].fixed  = arb_fixed_master[s];
    assign arb_if[s].limit  = arb_slot_limit[s];
    assign go[s]            = arb_if[s].go;
    assign owner[s]         = arb_if[s].owner;

    bmda_arbiter #(.SLOT_W(SLOT_W)) u_arb (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .a       (arb_if[s])
    );
  end

  // ==========================================================
  // transfer sequencing
  always_comb begin
    d      = q;
    d.done = '0;
    d.err  = '0;
    for (int unsigned m = 0; m < NM; m++) begin
      // an abort never touches a slave, it is answered from here
      if (live[m] && !dec[m].valid) begin
        d.done[m] = 1'b1;
        d.err[m]  = 1'b1;
        d.rdata[m] = '0;
      end
    end
    for (int unsigned s = 0; s < NS; s++) begin
      unique case (q.st[s])
        bmda_pkg::BMDA_IDLE: begin
          if (go[s]) begin
            d.st[s]    = bmda_pkg::BMDA_BUSY;
            d.sel[s]   = 1'b1;
            d.addr[s]  = m_addr[owner[s]];
            d.wr[s]    = m_write[owner[s]];
            d.wdata[s] = m_wdata[owner[s]];
            d.mst[s]   = owner[s];
            // chip select follows the owner's own decode, so masters never mix
            if (s == int'(bmda_pkg::S_EXT)) begin
              d.cs = 8'h01 << dec[owner[s]].cs;
            end
          end
        end
        bmda_pkg::BMDA_BUSY: begin
          // ready is accepted in the first select cycle, no wait state
          if (s_ready[s]) begin
            d.st[s]           = bmda_pkg::BMDA_IDLE;
            d.sel[s]          = 1'b0;
            d.done[q.mst[s]]  = 1'b1;
            d.rdata[q.mst[s]] = s_rdata[s];
            if (s == int'(bmda_pkg::S_EXT)) begin
              d.cs = 8'h00;
            end
          end
        end
        default: begin
          d.st[s]  = bmda_pkg::BMDA_IDLE;
          d.sel[s] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q      <= '0;
      q.st   <= {NS{bmda_pkg::BMDA_IDLE}};
      // the strap is caught every reset cycle, so the last one wins
      q.boot <= boot_select_pin;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // every port is a register copy, so no decode glitch leaves the block
  assign m_done               = q.done;
  assign m_err                = q.err;
  assign m_rdata              = q.rdata;
  assign s_sel                = q.sel;
  assign s_addr               = q.addr;
  assign s_write              = q.wr;
  assign s_wdata              = q.wdata;
  assign s_master             = q.mst;
  assign external_chip_select = q.cs;

endmodule : bmda_matrix
